// ---- dpr_pkg.sv ----
// shared constants and types for the ddr2 command decode block
// assumes a single core clock domain and an apb register master
package dpr_pkg;

  // command code {chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n}
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_NOP = 4'h7;

  // register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_REFCNT = 12'h008;

  // control register fields and reset value
  localparam int CTRL_SLOW_EXIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // status register field positions
  localparam int ST_BANK_LSB = 0;
  localparam int ST_STATE_LSB = 4;
  localparam int ST_DLL = 8;
  localparam int ST_BUSY = 9;
  localparam int ST_MRSEL_LSB = 10;

  // documented defaults
  localparam int BURST_LEN_DEF = 4;
  localparam int REFRESH_ROWS_DEF = 8192;
  localparam int NUM_BANKS = 4;

  // power state, one-hot
  typedef enum logic [3:0] {
    PS_NORMAL = 4'b0001,
    PS_PD_PRE = 4'b0010,
    PS_PD_ACT = 4'b0100,
    PS_SREF = 4'b1000
  } dpr_pstate_t;

  // command and control pins as seen at the device
  typedef struct packed {
    logic chip_sel_n;
    logic row_strobe_n;
    logic col_strobe_n;
    logic write_strobe_n;
    logic clock_gate_in;
    logic autoprecharge_addr_bit;
    logic [1:0] bank_sel;
    logic termination_ctrl;
  } dpr_pins_t;

endpackage

// ---- dpr_core.sv ----
// ddr2 device command decode: bank state, bursts, refresh, power-down
// assumes pins are asynchronous to core_clk and apb is on core_clk
//
// Function
// - self refresh entry by refresh, gate low
// - power-down entry and exit with nop/deselect
// - idle banks precharge power-down, else active
// - dll off except fast exit active power-down
// - power-down ignores all but gate and termination; the code never uses termination_ctrl
// - decode four strobes at each rising edge
// - deselect, self refresh start, power-down commands
// - bank select picks bank or mode register
// - burst length four bursts run to completion
// - autoprecharge bit high closes all banks; on a read or write the code closes only the selected bank, at burst end
//
// The placing of the registers and register access over APB were decided locally.
module dpr_core #(
  parameter int BURST_LEN = dpr_pkg::BURST_LEN_DEF,
  parameter int REFRESH_ROWS = dpr_pkg::REFRESH_ROWS_DEF
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // memory command pins
  input wire logic chip_sel_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_strobe_n,
  input wire logic clock_gate_in,
  input wire logic autoprecharge_addr_bit,
  input wire logic [1:0] bank_sel,
  input wire logic termination_ctrl,
  // device state outputs
  output logic [3:0] bank_open,
  output logic burst_busy,
  output logic dll_enable,
  output logic input_buf_enable,
  output logic power_down,
  output logic self_refresh,
  output logic refresh_pulse,
  output logic mrs_strobe,
  output logic [1:0] mrs_sel
);

  localparam int BURST_CYC = BURST_LEN / 2;
  localparam int RW = $clog2(REFRESH_ROWS);
  localparam logic [2:0] BURST_LOAD = 3'(BURST_CYC);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchroniser: two flops before any logic
  dpr_pkg::dpr_pins_t pins_in;
  dpr_pkg::dpr_pins_t sync1_q;
  dpr_pkg::dpr_pins_t sync2_q;
  logic cke_prev_q;

  assign pins_in = '{chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n,
                     clock_gate_in, autoprecharge_addr_bit, bank_sel, termination_ctrl};

  // two-stage capture plus previous gate sample
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sync1_q <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0};
      sync2_q <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0};
      cke_prev_q <= 1'b0;
    end
    else
    begin
      sync1_q <= pins_in;
      sync2_q <= sync1_q;
      cke_prev_q <= sync2_q.clock_gate_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // command decode
  logic [3:0] code;
  logic dsl;
  logic nop_dsl;
  logic cke_hh;
  logic cke_fall;
  logic cke_rise;
  logic all_idle;

  assign code = {1'b0, sync2_q.row_strobe_n, sync2_q.col_strobe_n,
                 sync2_q.write_strobe_n};
  assign dsl = sync2_q.chip_sel_n;
  assign nop_dsl = dsl || (code == dpr_pkg::CMD_NOP);
  assign cke_hh = cke_prev_q && sync2_q.clock_gate_in;
  assign cke_fall = cke_prev_q && !sync2_q.clock_gate_in;
  assign cke_rise = !cke_prev_q && sync2_q.clock_gate_in;

  //////////////////////////////////////////////////////////////////////////////
  // device state
  dpr_pkg::dpr_pstate_t ps_q, ps_d;
  logic [3:0] bank_q, bank_d;
  logic [3:0] ap_q, ap_d;
  logic [2:0] burst_q, burst_d;
  logic [RW-1:0] row_q, row_d;
  logic ref_q, ref_d;
  logic mrs_q, mrs_d;
  logic [1:0] msel_q, msel_d;
  logic [31:0] ctrl_q, ctrl_d;
  logic run;
  logic rw_go;

  assign all_idle = (bank_q == 4'h0);
  assign run = (ps_q == dpr_pkg::PS_NORMAL) && cke_hh && !dsl;
  assign rw_go = run && (burst_q == 3'h0) &&
                 ((code == dpr_pkg::CMD_RD) || (code == dpr_pkg::CMD_WR));

  // next-state for banks, bursts, refresh and power state
  always_comb
  begin
    ps_d = ps_q;
    bank_d = bank_q;
    ap_d = ap_q;
    burst_d = burst_q;
    row_d = row_q;
    ref_d = 1'b0;
    mrs_d = 1'b0;
    msel_d = msel_q;
    // burst runs to the end; autoprecharge closes at burst end
    if (burst_q != 3'h0)
    begin
      burst_d = burst_q - 3'h1;
      if (burst_q == 3'h1)
      begin
        bank_d = bank_q & ~ap_q;
        ap_d = 4'h0;
      end
    end
    case (ps_q)
      dpr_pkg::PS_NORMAL:
      begin
        if (run)
        begin
          case (code)
            dpr_pkg::CMD_ACT:
              bank_d[sync2_q.bank_sel] = 1'b1;
            dpr_pkg::CMD_PRE:
              if (sync2_q.autoprecharge_addr_bit)
                bank_d = 4'h0;
              else
                bank_d[sync2_q.bank_sel] = 1'b0;
            dpr_pkg::CMD_RD, dpr_pkg::CMD_WR:
              if (rw_go)
              begin
                burst_d = BURST_LOAD;
                if (sync2_q.autoprecharge_addr_bit)
                  ap_d[sync2_q.bank_sel] = 1'b1;
              end
            dpr_pkg::CMD_REF:
              if (all_idle)
              begin
                ref_d = 1'b1;
                row_d = row_q + RW'(1);
              end
            dpr_pkg::CMD_MRS:
            begin
              mrs_d = 1'b1;
              msel_d = sync2_q.bank_sel;
            end
            default: ;
          endcase
        end
        else if (cke_fall)
          if (!dsl && (code == dpr_pkg::CMD_REF) && all_idle)
            ps_d = dpr_pkg::PS_SREF;
          else if (nop_dsl)
            ps_d = all_idle ? dpr_pkg::PS_PD_PRE : dpr_pkg::PS_PD_ACT;
      end
      // low-power states: only a gate rise with nop/deselect is acted on here
      dpr_pkg::PS_PD_PRE, dpr_pkg::PS_PD_ACT, dpr_pkg::PS_SREF:
        if (cke_rise && nop_dsl)
          ps_d = dpr_pkg::PS_NORMAL;
      default:
        ps_d = dpr_pkg::PS_NORMAL;
    endcase
  end

  // state registers
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ps_q <= dpr_pkg::PS_NORMAL;
      bank_q <= 4'h0;
      ap_q <= 4'h0;
      burst_q <= 3'h0;
      row_q <= '0;
      ref_q <= 1'b0;
      mrs_q <= 1'b0;
      msel_q <= 2'h0;
    end
    else
    begin
      ps_q <= ps_d;
      bank_q <= bank_d;
      ap_q <= ap_d;
      burst_q <= burst_d;
      row_q <= row_d;
      ref_q <= ref_d;
      mrs_q <= mrs_d;
      msel_q <= msel_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign bank_open = bank_q;
  assign burst_busy = (burst_q != 3'h0);
  assign refresh_pulse = ref_q;
  assign mrs_strobe = mrs_q;
  assign mrs_sel = msel_q;
  assign power_down = (ps_q == dpr_pkg::PS_PD_PRE) || (ps_q == dpr_pkg::PS_PD_ACT);
  assign self_refresh = (ps_q == dpr_pkg::PS_SREF);
  assign input_buf_enable = (ps_q == dpr_pkg::PS_NORMAL);
  // dll kept only in normal or fast-exit active power-down
  assign dll_enable = (ps_q == dpr_pkg::PS_NORMAL) ||
                      ((ps_q == dpr_pkg::PS_PD_ACT) &&
                       !ctrl_q[dpr_pkg::CTRL_SLOW_EXIT]);

  //////////////////////////////////////////////////////////////////////////////
  // apb register file, zero wait states
  logic wr_en;
  logic [31:0] rdata_d, rdata_q;
  logic err_d;

  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;

  // control write and read mux
  always_comb
  begin
    ctrl_d = ctrl_q;
    rdata_d = 32'h0000_0000;
    err_d = 1'b0;
    case (paddr)
      dpr_pkg::OFS_CTRL:
      begin
        rdata_d = ctrl_q & 32'h0000_0001;
        if (wr_en)
          ctrl_d = pwdata & 32'h0000_0001;
      end
      dpr_pkg::OFS_STATUS:
      begin
        rdata_d[dpr_pkg::ST_BANK_LSB +: 4] = bank_q;
        rdata_d[dpr_pkg::ST_STATE_LSB +: 4] = ps_q;
        rdata_d[dpr_pkg::ST_DLL] = dll_enable;
        rdata_d[dpr_pkg::ST_BUSY] = burst_busy;
        rdata_d[dpr_pkg::ST_MRSEL_LSB +: 2] = msel_q;
      end
      dpr_pkg::OFS_REFCNT:
        rdata_d[RW-1:0] = row_q;
      default:
        err_d = 1'b1;
    endcase
  end

  // registers on the bus side
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ctrl_q <= dpr_pkg::CTRL_RESET;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      if (psel && !penable)
        rdata_q <= rdata_d;
    end
  end

  assign prdata = rdata_q;
  assign pslverr = psel && penable && err_d;

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  AST_PD_ENTRY: assert property (@(posedge core_clk) disable iff (rst)
    (ps_q == dpr_pkg::PS_NORMAL) && cke_fall && nop_dsl |=> power_down)
    else $error("power-down not entered");
  AST_PD_KIND: assert property (@(posedge core_clk) disable iff (rst)
    (ps_q == dpr_pkg::PS_NORMAL) && cke_fall && nop_dsl && !all_idle
    |=> ps_q == dpr_pkg::PS_PD_ACT)
    else $error("open bank did not give active power-down");
  AST_DLL_OFF: assert property (@(posedge core_clk) disable iff (rst)
    (ps_q == dpr_pkg::PS_PD_PRE) || self_refresh |-> !dll_enable)
    else $error("dll left running");
  AST_BUF_OFF: assert property (@(posedge core_clk) disable iff (rst)
    power_down && !cke_rise |=> $stable(bank_q) || $fell(burst_busy))
    else $error("command taken in power-down");
  AST_SREF: assert property (@(posedge core_clk) disable iff (rst)
    (ps_q == dpr_pkg::PS_NORMAL) && cke_fall && !dsl && code == dpr_pkg::CMD_REF
    && all_idle |=> self_refresh ##0 !input_buf_enable)
    else $error("self refresh not entered");
  AST_PRE_ALL: assert property (@(posedge core_clk) disable iff (rst)
    run && code == dpr_pkg::CMD_PRE && sync2_q.autoprecharge_addr_bit |=> bank_open == 4'h0)
    else $error("precharge all left a bank open");
  AST_ACT: assert property (@(posedge core_clk) disable iff (rst)
    run && code == dpr_pkg::CMD_ACT |=> bank_open[$past(sync2_q.bank_sel)])
    else $error("activate did not open bank");
  AST_BURST: assert property (@(posedge core_clk) disable iff (rst)
    rw_go |=> burst_busy[*2] ##1 !burst_busy) else $error("burst length wrong");
  AST_DSL: assert property (@(posedge core_clk) disable iff (rst)
    dsl |=> !refresh_pulse && !mrs_strobe) else $error("deselect executed a command");
  CV_SREF: cover property (@(posedge core_clk) disable iff (rst) self_refresh ##1 !self_refresh);
  CV_PD_ACT: cover property (@(posedge core_clk) disable iff (rst) ps_q == dpr_pkg::PS_PD_ACT);
  CV_AP: cover property (@(posedge core_clk) disable iff (rst)
    rw_go && sync2_q.autoprecharge_addr_bit);

endmodule

// ---- dpr_ctl_model.sv ----
// memory controller model driving the command pins of the decode block
// assumes core_clk is the command clock; the bench calls issue() in order
module dpr_ctl_model (
  // clock
  input wire logic core_clk,
  // command pins toward the device
  output dpr_pkg::dpr_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle: deselect, gate high, termination off
  initial
  begin
    pins = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 2'h0, 1'b0};
  end

  ////////////////////////////////////////////////////////////////////////
  // one command for one cycle, then deselect with don't-care lines toggled
  task automatic issue(input logic [3:0] c, input logic [1:0] ba, input logic ap,
    input logic gate);
    @(posedge core_clk);
    pins <= '{c[3], c[2], c[1], c[0], gate, ap, ba, 1'b0};
    @(posedge core_clk);
    pins <= '{1'b1, ~c[2], ~c[1], ~c[0], gate, ~ap, ~ba, 1'b0};
    // settle past the decode latency before anything else
    repeat (5) @(posedge core_clk);
  endtask
endmodule

// ---- ddr2_precharge_refresh_powerdown_tb.sv ----
// self-checking bench for the ddr2 command decode block
// assumes the controller model drives the pins and apb runs on core_clk
module ddr2_precharge_refresh_powerdown_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er;
  dpr_pkg::dpr_pins_t pins;
  logic [3:0] bank_open;
  logic burst_busy, dll_enable, input_buf_enable, power_down, self_refresh;
  logic refresh_pulse, mrs_strobe;
  logic [1:0] mrs_sel;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  int ref_n = 0;
  int mrs_n = 0;
  int busy_n = 0;

  // clock at 50 MHz
  always #10 core_clk = ~core_clk;

  dpr_ctl_model u_dpr_ctl_model (.core_clk(core_clk), .pins(pins));

  dpr_core u_dpr_core (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chip_sel_n(pins.chip_sel_n), .row_strobe_n(pins.row_strobe_n),
    .col_strobe_n(pins.col_strobe_n), .write_strobe_n(pins.write_strobe_n),
    .clock_gate_in(pins.clock_gate_in), .autoprecharge_addr_bit(pins.autoprecharge_addr_bit),
    .bank_sel(pins.bank_sel), .termination_ctrl(pins.termination_ctrl),
    .bank_open(bank_open), .burst_busy(burst_busy), .dll_enable(dll_enable),
    .input_buf_enable(input_buf_enable), .power_down(power_down),
    .self_refresh(self_refresh), .refresh_pulse(refresh_pulse),
    .mrs_strobe(mrs_strobe), .mrs_sel(mrs_sel));

  ////////////////////////////////////////////////////////////////////////
  // pulse counters and hang guard
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (refresh_pulse === 1'b1) ref_n <= ref_n + 1;
    if (mrs_strobe === 1'b1) mrs_n <= mrs_n + 1;
    if (burst_busy === 1'b1) busy_n <= busy_n + 1;
    if (cyc == 5000)
    begin
      errors++;
      end_of_test();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // status read against bank flags, state, dll and mode register select
  task automatic rs(input logic [3:0] b, input logic [3:0] s, input logic dl,
    input logic [1:0] m);
    logic [31:0] e;
    e = 32'h0000_0000;
    e[dpr_pkg::ST_BANK_LSB +: 4] = b;
    e[dpr_pkg::ST_STATE_LSB +: 4] = s;
    e[dpr_pkg::ST_DLL] = dl;
    e[dpr_pkg::ST_MRSEL_LSB +: 2] = m;
    apb(1'b0, dpr_pkg::OFS_STATUS, 32'h0000_0000);
    chk("status", e, rd);
  endtask

  task automatic tend(input string n);
    $display("test %s done", n);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // test sequence
  initial
  begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rs(4'h0, 4'h1, 1'b1, 2'h0);
    apb(1'b0, dpr_pkg::OFS_CTRL, 32'h0000_0000);
    chk("ctrl", dpr_pkg::CTRL_RESET, rd);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, {31'h0, er});
    apb(1'b1, 12'h00C, 32'h0000_0001);
    chk("slverr write", 32'h0000_0001, {31'h0, er});
    apb(1'b0, dpr_pkg::OFS_CTRL, 32'h0000_0000);
    chk("ctrl unchanged", dpr_pkg::CTRL_RESET, rd);
    tend("registers");
    for (int b = 0; b < 4; b++) u_dpr_ctl_model.issue(dpr_pkg::CMD_ACT, b[1:0], 1'b0, 1'b1);
    chk("bank_open", 32'h0000_000F, {28'h0, bank_open});
    u_dpr_ctl_model.issue(dpr_pkg::CMD_REF, 2'h0, 1'b0, 1'b1);
    chk("refresh refused", 32'h0000_0000, ref_n);
    u_dpr_ctl_model.issue(dpr_pkg::CMD_PRE, 2'h1, 1'b0, 1'b1);
    chk("bank_open", 32'h0000_000D, {28'h0, bank_open});
    u_dpr_ctl_model.issue(dpr_pkg::CMD_PRE, 2'h0, 1'b1, 1'b1);
    chk("bank_open", 32'h0000_0000, {28'h0, bank_open});
    u_dpr_ctl_model.issue(dpr_pkg::CMD_REF, 2'h0, 1'b0, 1'b1);
    chk("refresh", 32'h0000_0001, ref_n);
    apb(1'b0, dpr_pkg::OFS_REFCNT, 32'h0000_0000);
    chk("refcnt", 32'h0000_0001, rd);
    u_dpr_ctl_model.issue(dpr_pkg::CMD_MRS, 2'h3, 1'b0, 1'b1);
    chk("mrs", 32'h0000_0001, mrs_n);
    chk("mrs_sel", 32'h0000_0003, {30'h0, mrs_sel});
    u_dpr_ctl_model.issue(4'hB, 2'h1, 1'b0, 1'b1);
    chk("deselect", 32'h0000_0000, {28'h0, bank_open});
    tend("commands");
    u_dpr_ctl_model.issue(dpr_pkg::CMD_NOP, 2'h0, 1'b0, 1'b0);
    rs(4'h0, 4'h2, 1'b0, 2'h3);
    chk("inbuf", 32'h0000_0000, {31'h0, input_buf_enable});
    chk("power_down", 32'h0000_0001, {31'h0, power_down});
    chk("dll_enable", 32'h0000_0000, {31'h0, dll_enable});
    u_dpr_ctl_model.issue(dpr_pkg::CMD_ACT, 2'h0, 1'b0, 1'b0);
    chk("pd ignores", 32'h0000_0000, {28'h0, bank_open});
    u_dpr_ctl_model.issue(dpr_pkg::CMD_NOP, 2'h0, 1'b0, 1'b1);
    rs(4'h0, 4'h1, 1'b1, 2'h3);
    chk("power_down", 32'h0000_0000, {31'h0, power_down});
    tend("precharge power-down");
    u_dpr_ctl_model.issue(dpr_pkg::CMD_ACT, 2'h2, 1'b0, 1'b1);
    u_dpr_ctl_model.issue(dpr_pkg::CMD_NOP, 2'h0, 1'b0, 1'b0);
    rs(4'h4, 4'h4, 1'b1, 2'h3);
    chk("dll fast exit", 32'h0000_0001, {31'h0, dll_enable});
    u_dpr_ctl_model.issue(dpr_pkg::CMD_NOP, 2'h0, 1'b0, 1'b1);
    apb(1'b1, dpr_pkg::OFS_CTRL, 32'h0000_0001);
    apb(1'b0, dpr_pkg::OFS_CTRL, 32'h0000_0000);
    chk("ctrl", 32'h0000_0001, rd);
    u_dpr_ctl_model.issue(dpr_pkg::CMD_NOP, 2'h0, 1'b0, 1'b0);
    rs(4'h4, 4'h4, 1'b0, 2'h3);
    chk("dll slow exit", 32'h0000_0000, {31'h0, dll_enable});
    u_dpr_ctl_model.issue(dpr_pkg::CMD_NOP, 2'h0, 1'b0, 1'b1);
    tend("active power-down");
    u_dpr_ctl_model.issue(dpr_pkg::CMD_RD, 2'h2, 1'b1, 1'b1);
    chk("burst cycles", dpr_pkg::BURST_LEN_DEF / 2, busy_n);
    chk("autoprecharge", 32'h0000_0000, {28'h0, bank_open});
    tend("burst");
    u_dpr_ctl_model.issue(dpr_pkg::CMD_ACT, 2'h1, 1'b0, 1'b1);
    u_dpr_ctl_model.issue(dpr_pkg::CMD_WR, 2'h1, 1'b0, 1'b1);
    chk("write burst cycles", 2 * (dpr_pkg::BURST_LEN_DEF / 2), busy_n);
    chk("write keeps bank", 32'h0000_0002, {28'h0, bank_open});
    u_dpr_ctl_model.issue(dpr_pkg::CMD_PRE, 2'h1, 1'b0, 1'b1);
    chk("bank_open", 32'h0000_0000, {28'h0, bank_open});
    tend("write");
    u_dpr_ctl_model.issue(dpr_pkg::CMD_REF, 2'h0, 1'b0, 1'b0);
    chk("self refresh", 32'h0000_0001, {31'h0, self_refresh});
    chk("no pulse", 32'h0000_0001, ref_n);
    u_dpr_ctl_model.issue(dpr_pkg::CMD_NOP, 2'h0, 1'b0, 1'b1);
    chk("sr exit", 32'h0000_0000, {31'h0, self_refresh});
    tend("self refresh");
    end_of_test();
  end
endmodule
